// *** common/tcc_pkg.sv ***
// Shared constants and types for the timer counter capture channel.
// Assumes a single master clock domain; all control bits arrive as plain ports.
package tcc_pkg;

  localparam int CV_W        = 16;
  localparam logic [CV_W-1:0] CV_MAX  = 16'hFFFF;
  localparam logic [CV_W-1:0] CV_ZERO = 16'h0000;
  localparam logic [CV_W-1:0] CV_ONE  = 16'h0001;

  // Prescaler: tap bits give master clock divided by 2, 8, 32, 128, 1024
  localparam int PRE_W    = 10;
  localparam int N_INTCLK = 5;
  localparam int DIV_TAP [0:N_INTCLK-1] = '{0, 2, 4, 6, 9};
  localparam logic [PRE_W-1:0] PRE_ONE = 10'h001;
  localparam logic [PRE_W-1:0] PRE_ZERO = 10'h000;

  // Clock source select: 0..4 internal divided clocks, 5..7 external inputs
  localparam logic [2:0] CLKSRC_EXT0 = 3'h5;

  // Burst gate select
  localparam logic [1:0] BURST_NONE = 2'h0;

  // Edge select encodings (trigger edge, load edges)
  localparam logic [1:0] EDGE_NONE    = 2'h0;
  localparam logic [1:0] EDGE_RISING  = 2'h1;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;

  // Waveform external event select
  localparam logic [1:0] EVT_LINE_B = 2'h0;

  // Chaining select for each external clock input
  localparam logic [1:0] CHAIN_PIN  = 2'h0;
  localparam logic [1:0] CHAIN_NONE = 2'h1;
  localparam logic [1:0] CHAIN_SIB0 = 2'h2;
  localparam logic [1:0] CHAIN_SIB1 = 2'h3;

  // Synchroniser bit layout
  localparam int SYNC_W   = 7;
  localparam int SY_PIN0  = 0;
  localparam int SY_SIB0  = 3;
  localparam int SY_SIB1  = 4;
  localparam int SY_LINEA = 5;
  localparam int SY_LINEB = 6;

  // Sticky status flag positions
  localparam int ST_W      = 6;
  localparam int ST_OVF    = 0;
  localparam int ST_OVRUN  = 1;
  localparam int ST_CMPC   = 2;
  localparam int ST_LOADA  = 3;
  localparam int ST_LOADB  = 4;
  localparam int ST_EXTTRG = 5;
  localparam logic [ST_W-1:0] ST_RESET = 6'h00;

  typedef enum logic [2:0] {
    TCC_CLK_DISABLED = 3'b001,
    TCC_CLK_STOPPED  = 3'b010,
    TCC_CLK_RUNNING  = 3'b100
  } tcc_clk_state_t;

endpackage : tcc_pkg

// *** core/tcc_prescaler.sv ***
// Free running prescaler giving rise and fall enables of the divided clocks.
// Assumes the master clock and its asynchronous active-low reset.
`timescale 1ns/1ns
module tcc_prescaler
  import tcc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  output logic [N_INTCLK-1:0]      rise,
  output logic [N_INTCLK-1:0]      fall
);

  logic [PRE_W-1:0] count;
  logic [PRE_W-1:0] next_count;

  always_comb begin
    next_count = count + PRE_ONE;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= PRE_ZERO;
    end else begin
      count <= next_count;
    end
  end

  // Edge enables fire in the cycle before the tap bit changes
  for (genvar i = 0; i < N_INTCLK; i++) begin : g_tap
    assign rise[i] = next_count[DIV_TAP[i]] & ~count[DIV_TAP[i]]; // RQ23
    assign fall[i] = ~next_count[DIV_TAP[i]] & count[DIV_TAP[i]]; // RQ23
  end

endmodule : tcc_prescaler

// *** core/tcc_channel.sv ***
// One timer counter channel in capture mode with clock chaining and sync trigger.
// Assumes pins are asynchronous; commands and reads are one-cycle pulses on SYS_CLK.
// Notes on behaviour
// RQ1 - 16-bit counter steps up on each valid selected-clock edge; value always visible.
// RQ2 - Wrap from all ones to zero sets the overflow flag.
// RQ3 - Trigger clears counter at the next valid counting edge, not at once.
// RQ4 - Block mode routes each external clock input to a pin or sibling line A.
// RQ5 - Clock select picks five divided clocks or three external inputs.
// RQ6 - Invert bit makes counting use the opposite clock edge.
// RQ7 - Burst gate passes the counting clock only while chosen input is high.
// RQ8 - External clocks hold each level over one master period, under rate/2.5.
// RQ9 - Enable and disable commands control the clock; status shows enabled.
// RQ10 - Load B or compare C may disable; only enable command re-enables.
// RQ11 - Any trigger starts the counter clock when the clock is enabled.
// RQ12 - Load B or compare C may stop; start and stop ignored while disabled.
// RQ13 - Waveform bit picks mode; capture uses lines as inputs, waveform drives them; line B is not driven while it is the event line.
// RQ14 - Software trigger and block sync command each trigger the channel.
// RQ15 - Compare C trigger enable triggers when counter equals compare value.
// RQ16 - Waveform external event on line B or external inputs, trigger when enabled.
// RQ17 - Capture trigger uses line A or B with chosen edge; zero disables.
// RQ18 - External trigger pulses must last longer than one master period.
// RQ19 - Every trigger takes effect at the next active counting edge.
// RQ20 - Capture registers A and B latch counter on their chosen line A edge.
// RQ21 - A loads after trigger or B load; B loads only after A loads.
// RQ22 - Reloading an unread capture register overwrites it and sets overrun.
// RQ23 - Internal clocks are master clock divided by 2, 8, 32, 128, 1024.
// RQ24 - Interrupt output high while any enabled status flag is set.
`timescale 1ns/1ns
module tcc_channel
  import tcc_pkg::*;
(
  input  wire logic                   SYS_CLK,
  input  wire logic                   RST_N,
  input  wire logic [2:0]             EXTERNAL_CLOCK_PINS,
  input  wire logic [1:0]             SIBLING_LINE_A,
  input  wire logic                   IO_LINE_A_IN,
  output logic                        IO_LINE_A_OUT,
  output logic                        IO_LINE_A_OE,
  input  wire logic                   IO_LINE_B_IN,
  output logic                        IO_LINE_B_OUT,
  output logic                        IO_LINE_B_OE,
  input  wire logic [5:0]             BLOCK_MODE_CHAIN,
  input  wire logic                   SYNC_CMD,
  input  wire logic                   CLOCK_ENABLE_CMD,
  input  wire logic                   CLOCK_DISABLE_CMD,
  input  wire logic                   SOFTWARE_TRIGGER_CMD,
  input  wire logic [2:0]             CLOCK_SOURCE_SELECT,
  input  wire logic                   CLOCK_INVERT,
  input  wire logic [1:0]             BURST_SELECT,
  input  wire logic                   WAVE_MODE,
  input  wire logic                   LOAD_B_DISABLES_CLOCK,
  input  wire logic                   LOAD_B_STOPS_CLOCK,
  input  wire logic                   COMPARE_C_DISABLES_CLOCK,
  input  wire logic                   COMPARE_C_STOPS_CLOCK,
  input  wire logic                   COMPARE_C_TRIGGER_ENABLE,
  input  wire logic [1:0]             EXT_EVENT_SELECT,
  input  wire logic                   EXT_EVENT_TRIGGER_ENABLE,
  input  wire logic                   EXT_TRIGGER_SOURCE_SELECT,
  input  wire logic [1:0]             EXT_TRIGGER_EDGE_SELECT,
  input  wire logic [1:0]             LOAD_A_EDGE_SELECT,
  input  wire logic [1:0]             LOAD_B_EDGE_SELECT,
  input  wire logic [tcc_pkg::CV_W-1:0] COMPARE_REG_C,
  input  wire logic                   CAPTURE_A_READ,
  input  wire logic                   CAPTURE_B_READ,
  input  wire logic                   STATUS_READ,
  input  wire logic [tcc_pkg::ST_W-1:0] INTERRUPT_MASK,
  output logic [tcc_pkg::CV_W-1:0]    COUNTER_VALUE,
  output logic [tcc_pkg::CV_W-1:0]    CAPTURE_REG_A,
  output logic [tcc_pkg::CV_W-1:0]    CAPTURE_REG_B,
  output logic [tcc_pkg::ST_W-1:0]    CHANNEL_STATUS,
  output logic                        CLOCK_ENABLED_STATUS,
  output logic                        INTERRUPT
);
  import tcc_pkg::*;

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = ((sel == EDGE_RISING) && r) || ((sel == EDGE_FALLING) && f) || ((sel == EDGE_BOTH) && (r || f));
  endfunction : edge_hit

  // Pin synchronisers plus a delay stage for edge detection
  logic [SYNC_W-1:0] sync1, sync2, sync3;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {IO_LINE_B_IN, IO_LINE_A_IN, SIBLING_LINE_A, EXTERNAL_CLOCK_PINS};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  logic [N_INTCLK-1:0] pre_rise, pre_fall;
  tcc_prescaler u_prescaler (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .rise  (pre_rise),
    .fall  (pre_fall)
  );

  // External clock inputs: pin or sibling line A
  logic [2:0] xc_now, xc_prev, xc_rise, xc_fall;
  for (genvar n = 0; n < 3; n++) begin : g_chain
    logic [1:0] sel;
    assign sel        = BLOCK_MODE_CHAIN[2*n +: 2];
    assign xc_now[n]  = (sel == CHAIN_PIN)  ? sync2[SY_PIN0+n] :                   // RQ4
                        (sel == CHAIN_SIB0) ? sync2[SY_SIB0] :
                        (sel == CHAIN_SIB1) ? sync2[SY_SIB1] : 1'b0;
    assign xc_prev[n] = (sel == CHAIN_PIN)  ? sync3[SY_PIN0+n] :
                        (sel == CHAIN_SIB0) ? sync3[SY_SIB0] :
                        (sel == CHAIN_SIB1) ? sync3[SY_SIB1] : 1'b0;
    assign xc_rise[n] = xc_now[n] & ~xc_prev[n];
    assign xc_fall[n] = ~xc_now[n] & xc_prev[n];
  end

  logic a_rise, a_fall, b_rise, b_fall;
  assign a_rise = sync2[SY_LINEA] & ~sync3[SY_LINEA];
  assign a_fall = ~sync2[SY_LINEA] & sync3[SY_LINEA];
  assign b_rise = sync2[SY_LINEB] & ~sync3[SY_LINEB];
  assign b_fall = ~sync2[SY_LINEB] & sync3[SY_LINEB];

  // Counting clock selection, inversion and burst gating
  logic sel_rise, sel_fall, gate_ok, count_tick;
  always_comb begin
    if (CLOCK_SOURCE_SELECT < CLKSRC_EXT0) begin
      sel_rise = pre_rise[CLOCK_SOURCE_SELECT];                                   // RQ5
      sel_fall = pre_fall[CLOCK_SOURCE_SELECT];
    end else begin
      sel_rise = xc_rise[2'(CLOCK_SOURCE_SELECT - CLKSRC_EXT0)];                  // RQ5
      sel_fall = xc_fall[2'(CLOCK_SOURCE_SELECT - CLKSRC_EXT0)];
    end
    gate_ok    = (BURST_SELECT == BURST_NONE) ? 1'b1 : xc_now[2'(BURST_SELECT - 2'h1)]; // RQ7
    count_tick = (CLOCK_INVERT ? sel_fall : sel_rise) && gate_ok;                 // RQ6
  end

  // Trigger sources
  logic cpc_event, ext_trigger, trigger;
  logic cap_src_r, cap_src_f, evt_r, evt_f;
  always_comb begin
    cap_src_r = EXT_TRIGGER_SOURCE_SELECT ? b_rise : a_rise;
    cap_src_f = EXT_TRIGGER_SOURCE_SELECT ? b_fall : a_fall;
    evt_r     = (EXT_EVENT_SELECT == EVT_LINE_B) ? b_rise : xc_rise[2'(EXT_EVENT_SELECT - 2'h1)];
    evt_f     = (EXT_EVENT_SELECT == EVT_LINE_B) ? b_fall : xc_fall[2'(EXT_EVENT_SELECT - 2'h1)];
    if (WAVE_MODE) begin
      ext_trigger = EXT_EVENT_TRIGGER_ENABLE && edge_hit(EXT_TRIGGER_EDGE_SELECT, evt_r, evt_f); // RQ16
    end else begin
      ext_trigger = edge_hit(EXT_TRIGGER_EDGE_SELECT, cap_src_r, cap_src_f);      // RQ17
    end
    trigger = SOFTWARE_TRIGGER_CMD || SYNC_CMD || ext_trigger ||                 // RQ14
              (COMPARE_C_TRIGGER_ENABLE && cpc_event);                           // RQ15
  end

  // Capture load decisions
  logic a_loaded, a_unread, b_unread;
  logic lda_load, ldb_load, overrun_ev;
  always_comb begin
    lda_load   = !WAVE_MODE && edge_hit(LOAD_A_EDGE_SELECT, a_rise, a_fall) && !a_loaded; // RQ20 RQ21
    ldb_load   = !WAVE_MODE && edge_hit(LOAD_B_EDGE_SELECT, a_rise, a_fall) && a_loaded;  // RQ20 RQ21
    overrun_ev = (lda_load && a_unread) || (ldb_load && b_unread);               // RQ22
  end

  // Clock control state
  tcc_clk_state_t clk_state, next_clk_state;
  logic disable_ev, stop_ev;
  always_comb begin
    disable_ev = CLOCK_DISABLE_CMD || (!WAVE_MODE && ldb_load && LOAD_B_DISABLES_CLOCK) || // RQ10
                 (WAVE_MODE && cpc_event && COMPARE_C_DISABLES_CLOCK);
    stop_ev    = (!WAVE_MODE && ldb_load && LOAD_B_STOPS_CLOCK) ||                // RQ12
                 (WAVE_MODE && cpc_event && COMPARE_C_STOPS_CLOCK);
    next_clk_state = clk_state;
    unique case (clk_state)
      TCC_CLK_DISABLED: begin
        if (CLOCK_ENABLE_CMD && !disable_ev) begin
          next_clk_state = TCC_CLK_STOPPED;                                        // RQ9 RQ10
        end
      end
      TCC_CLK_STOPPED, TCC_CLK_RUNNING: begin
        if (disable_ev) begin
          next_clk_state = TCC_CLK_DISABLED;                                       // RQ9
        end else if (trigger) begin
          next_clk_state = TCC_CLK_RUNNING;                                        // RQ11
        end else if (stop_ev) begin
          next_clk_state = TCC_CLK_STOPPED;                                        // RQ12
        end
      end
      default: next_clk_state = TCC_CLK_DISABLED;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      clk_state <= TCC_CLK_DISABLED;
    end else begin
      clk_state <= next_clk_state;
    end
  end

  // Counter, pending trigger and compare C
  logic            trig_pending, next_trig_pending;
  logic [CV_W-1:0] next_cv;
  logic            next_cpc_event, count_step, ovf_ev;
  always_comb begin
    count_step        = count_tick && (clk_state == TCC_CLK_RUNNING);
    next_trig_pending = trigger || (trig_pending && !count_step);                 // RQ19
    ovf_ev            = count_step && !trig_pending && (COUNTER_VALUE == CV_MAX); // RQ2
    next_cv           = COUNTER_VALUE;
    if (count_step) begin
      next_cv = trig_pending ? CV_ZERO : COUNTER_VALUE + CV_ONE;                  // RQ1 RQ3
    end
    next_cpc_event    = count_step && (next_cv == COMPARE_REG_C);                 // RQ15
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      COUNTER_VALUE <= CV_ZERO;
      trig_pending  <= 1'b0;
      cpc_event     <= 1'b0;
    end else begin
      COUNTER_VALUE <= next_cv;
      trig_pending  <= next_trig_pending;
      cpc_event     <= next_cpc_event;
    end
  end

  // Capture registers and load ordering
  logic            next_a_loaded, next_a_unread, next_b_unread;
  logic [CV_W-1:0] next_cap_a, next_cap_b;
  always_comb begin
    next_a_loaded = a_loaded;
    if (lda_load) begin
      next_a_loaded = 1'b1;                                                        // RQ21
    end else if (ldb_load || trigger) begin
      next_a_loaded = 1'b0;                                                        // RQ21
    end
    next_a_unread = lda_load || (a_unread && !CAPTURE_A_READ);                    // RQ22
    next_b_unread = ldb_load || (b_unread && !CAPTURE_B_READ);                    // RQ22
    next_cap_a    = lda_load ? COUNTER_VALUE : CAPTURE_REG_A;                     // RQ20
    next_cap_b    = ldb_load ? COUNTER_VALUE : CAPTURE_REG_B;                     // RQ20
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      a_loaded      <= 1'b0;
      a_unread      <= 1'b0;
      b_unread      <= 1'b0;
      CAPTURE_REG_A <= CV_ZERO;
      CAPTURE_REG_B <= CV_ZERO;
    end else begin
      a_loaded      <= next_a_loaded;
      a_unread      <= next_a_unread;
      b_unread      <= next_b_unread;
      CAPTURE_REG_A <= next_cap_a;
      CAPTURE_REG_B <= next_cap_b;
    end
  end

  // Sticky status flags and interrupt
  logic [ST_W-1:0] events, next_status;
  logic            next_interrupt, next_enabled;
  always_comb begin
    events              = '0;
    events[ST_OVF]      = ovf_ev;                                                  // RQ2
    events[ST_OVRUN]    = overrun_ev;                                              // RQ22
    events[ST_CMPC]     = cpc_event;
    events[ST_LOADA]    = lda_load;
    events[ST_LOADB]    = ldb_load;
    events[ST_EXTTRG]   = ext_trigger;
    next_status         = events | (CHANNEL_STATUS & {ST_W{!STATUS_READ}});
    next_interrupt      = |(next_status & INTERRUPT_MASK);                          // RQ24
    next_enabled        = (next_clk_state != TCC_CLK_DISABLED);                     // RQ9
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CHANNEL_STATUS       <= ST_RESET;
      INTERRUPT            <= 1'b0;
      CLOCK_ENABLED_STATUS <= 1'b0;
    end else begin
      CHANNEL_STATUS       <= next_status;
      INTERRUPT            <= next_interrupt;
      CLOCK_ENABLED_STATUS <= next_enabled;
    end
  end

  // Line directions; waveform level generation lies outside this channel
  assign IO_LINE_A_OE  = WAVE_MODE;                                                // RQ13
  assign IO_LINE_B_OE  = WAVE_MODE && (EXT_EVENT_SELECT != EVT_LINE_B);            // RQ13
  assign IO_LINE_A_OUT = 1'b0;
  assign IO_LINE_B_OUT = 1'b0;

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  property p_count_up;
    count_step && !trig_pending |=> COUNTER_VALUE == $past(COUNTER_VALUE) + CV_ONE;
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not step"); // RQ1

  property p_overflow;
    ovf_ev |=> CHANNEL_STATUS[ST_OVF] && COUNTER_VALUE == CV_ZERO;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag missing"); // RQ2

  property p_trig_clear;
    trig_pending && count_step |=> COUNTER_VALUE == CV_ZERO;
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger did not clear counter"); // RQ3

  property p_enable;
    clk_state == TCC_CLK_DISABLED && CLOCK_ENABLE_CMD && !CLOCK_DISABLE_CMD ##1 !CLOCK_DISABLE_CMD
      |=> CLOCK_ENABLED_STATUS;
  endproperty
  a_enable: assert property (p_enable) else $error("enable status not shown"); // RQ9

  property p_ldb_disable;
    ldb_load && LOAD_B_DISABLES_CLOCK |=> clk_state == TCC_CLK_DISABLED ##1 !CLOCK_ENABLED_STATUS;
  endproperty
  a_ldb_disable: assert property (p_ldb_disable) else $error("load B did not disable"); // RQ10

  property p_start;
    trigger && clk_state != TCC_CLK_DISABLED && !disable_ev |=> clk_state == TCC_CLK_RUNNING;
  endproperty
  a_start: assert property (p_start) else $error("trigger did not start clock"); // RQ11

  property p_no_start_disabled;
    clk_state == TCC_CLK_DISABLED && !CLOCK_ENABLE_CMD |=> clk_state == TCC_CLK_DISABLED;
  endproperty
  a_no_start_disabled: assert property (p_no_start_disabled) else $error("disabled clock moved"); // RQ12

  property p_line_dir;
    !WAVE_MODE |-> !IO_LINE_A_OE && !IO_LINE_B_OE;
  endproperty
  a_line_dir: assert property (p_line_dir) else $error("line driven in capture mode"); // RQ13

  property p_b_order;
    !a_loaded |=> $stable(CAPTURE_REG_B);
  endproperty
  a_b_order: assert property (p_b_order) else $error("B loaded before A"); // RQ21

  property p_overrun;
    lda_load && a_unread |=> CHANNEL_STATUS[ST_OVRUN] && CAPTURE_REG_A == $past(COUNTER_VALUE);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // RQ22

endmodule : tcc_channel

// *** testbench/tcc_pins_model.sv ***
// Pin-side model: external clock pin 0, capture line A and trigger line B.
// Assumes the bench requests line levels; pins 1 and 2 sit on pull-downs.
`timescale 1ns/1ns
module tcc_pins_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       a_req,
  input  wire logic       b_req,
  output logic [2:0]      pins,
  output logic            line_a,
  output logic            line_b
);
  logic [1:0] phase;
  logic       ext_clk;
  // Clock levels last three master periods; lines follow requests held for many periods
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase   <= 2'h0;
      ext_clk <= 1'b0;
      line_a  <= 1'b0;
      line_b  <= 1'b0;
    end else begin
      line_a <= a_req;
      line_b <= b_req;
      if (run) begin
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        if (phase == 2'h2) begin
          ext_clk <= ~ext_clk;
        end
      end
    end
  end
  assign pins = {2'b00, ext_clk};
endmodule : tcc_pins_model

// *** testbench/test_tcc_channel.sv ***
// Testbench for the capture channel: rates, clock control, triggers, capture, gating.
// Assumes tcc_pkg and the pin model on the external clock pin and both lines.
`timescale 1ns/1ns
module test_tcc_channel;
  import tcc_pkg::*;
  logic sys_clk = 0, rst_n = 0, run = 0, a_req = 0, b_req = 0, a_out, b_out, a_oe, b_oe, line_a, line_b;
  logic sync_cmd = 0, en_cmd = 0, dis_cmd = 0, sw_cmd = 0, inv = 0, wave = 0, ldb_dis = 0, ldb_stop = 0;
  logic cpc_trg = 0, etrg_src = 0, a_rd = 0, st_rd = 0, ev_en = 0, cpc_dis = 0, clk_en, irq;
  logic [1:0] sib = 0, burst = 0, etrg_edge = 0, lda_edge = 0, ldb_edge = 0;
  logic [2:0] src = 0, pins;
  logic [5:0] chain = 0;
  logic [CV_W-1:0] rc = 16'h0000, cv, ra, rb, d;
  logic [ST_W-1:0] mask = 6'h02, st;
  int mismatches = 0, num_checks = 0;
  int divs [0:4] = '{2, 8, 32, 128, 1024};
  always #50 sys_clk = ~sys_clk;
  tcc_pins_model tcc_pins_model_i (.clk(sys_clk), .rst_n(rst_n), .run(run), .a_req(a_req), .b_req(b_req),
    .pins(pins), .line_a(line_a), .line_b(line_b));
  tcc_channel tcc_channel_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .EXTERNAL_CLOCK_PINS(pins),
    .SIBLING_LINE_A(sib), .IO_LINE_A_IN(a_oe ? a_out : line_a), .IO_LINE_A_OUT(a_out), .IO_LINE_A_OE(a_oe),
    .IO_LINE_B_IN(b_oe ? b_out : line_b), .IO_LINE_B_OUT(b_out), .IO_LINE_B_OE(b_oe),
    .BLOCK_MODE_CHAIN(chain), .SYNC_CMD(sync_cmd), .CLOCK_ENABLE_CMD(en_cmd), .CLOCK_DISABLE_CMD(dis_cmd),
    .SOFTWARE_TRIGGER_CMD(sw_cmd), .CLOCK_SOURCE_SELECT(src), .CLOCK_INVERT(inv), .BURST_SELECT(burst),
    .WAVE_MODE(wave), .LOAD_B_DISABLES_CLOCK(ldb_dis), .LOAD_B_STOPS_CLOCK(ldb_stop),
    .COMPARE_C_DISABLES_CLOCK(cpc_dis), .COMPARE_C_STOPS_CLOCK(1'b0), .COMPARE_C_TRIGGER_ENABLE(cpc_trg),
    .EXT_EVENT_SELECT(2'h0), .EXT_EVENT_TRIGGER_ENABLE(ev_en), .EXT_TRIGGER_SOURCE_SELECT(etrg_src),
    .EXT_TRIGGER_EDGE_SELECT(etrg_edge), .LOAD_A_EDGE_SELECT(lda_edge), .LOAD_B_EDGE_SELECT(ldb_edge),
    .COMPARE_REG_C(rc), .CAPTURE_A_READ(a_rd), .CAPTURE_B_READ(1'b0), .STATUS_READ(st_rd),
    .INTERRUPT_MASK(mask), .COUNTER_VALUE(cv), .CAPTURE_REG_A(ra), .CAPTURE_REG_B(rb),
    .CHANNEL_STATUS(st), .CLOCK_ENABLED_STATUS(clk_en), .INTERRUPT(irq));
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : wait_cyc
  // Counter advance over n cycles, sampled away from the active edge
  task automatic span(input int n);
    logic [CV_W-1:0] v0;
    @(negedge sys_clk);
    v0 = cv;
    repeat (n) @(negedge sys_clk);
    d = cv - v0;
  endtask : span
  // One-cycle command pulse: 0 enable, 1 disable, 2 trigger, 3 sync, 4 status read, 5 A read
  task automatic pulse(input int k);
    @(posedge sys_clk);
    case (k)
      0: en_cmd <= 1'b1;
      1: dis_cmd <= 1'b1;
      2: sw_cmd <= 1'b1;
      3: sync_cmd <= 1'b1;
      4: st_rd <= 1'b1;
      default: a_rd <= 1'b1;
    endcase
    @(posedge sys_clk);
    {en_cmd, dis_cmd, sw_cmd, sync_cmd, st_rd, a_rd} <= 6'h00;
  endtask : pulse
  task automatic line(input int b, input int hi);
    @(posedge sys_clk);
    if (b == 1) b_req <= 1'b1;
    else a_req <= 1'b1;
    repeat (hi) @(posedge sys_clk);
    {a_req, b_req} <= 2'b00;
    wait_cyc(hi);
  endtask : line
  task automatic t_rates;
    pulse(0);
    pulse(2);
    wait_cyc(1);
    check(clk_en === 1'b1, "clock not enabled");
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      src <= i[2:0];
      wait_cyc(divs[i] + 4);
      span(4 * divs[i]);
      check(d === 16'h0004, "wrong internal clock rate");
    end
    @(posedge sys_clk);
    src <= 3'h0;
  endtask : t_rates
  task automatic t_clock_ctrl;
    pulse(1);
    wait_cyc(2);
    check(clk_en === 1'b0, "clock still enabled");
    span(20);
    check(d === 16'h0000, "disabled counter moved");
    pulse(2);
    span(20);
    check(d === 16'h0000, "trigger started a disabled clock");
    pulse(0);
    span(20);
    check(d === 16'h0000, "enable alone started the clock");
    pulse(2);
    wait_cyc(4);
    span(20);
    check(d === 16'h000A, "trigger did not start clock");
  endtask : t_clock_ctrl
  task automatic t_triggers;
    wait_cyc(40);
    pulse(3);
    wait_cyc(3);
    check(cv < 16'h0004, "sync did not clear counter");
    @(posedge sys_clk);
    etrg_src <= 1'b1;
    wait_cyc(40);
    line(1, 6);
    check(st[ST_EXTTRG] === 1'b0 && cv > 16'h0014, "edge select zero still triggered");
    @(posedge sys_clk);
    etrg_edge <= EDGE_RISING;
    line(1, 6);
    check(st[ST_EXTTRG] === 1'b1 && cv < 16'h0008, "line B edge did not trigger");
    @(posedge sys_clk);
    etrg_edge <= EDGE_NONE;
    rc <= 16'h0014;
    cpc_trg <= 1'b1;
    pulse(4);
    wait_cyc(200);
    check(st[ST_CMPC] === 1'b1 && cv < 16'h0017, "compare C did not trigger");
    @(posedge sys_clk);
    cpc_trg <= 1'b0;
  endtask : t_triggers
  task automatic t_capture;
    @(posedge sys_clk);
    lda_edge <= EDGE_RISING;
    ldb_edge <= EDGE_FALLING;
    ldb_dis <= 1'b1;
    pulse(4);
    pulse(2);
    wait_cyc(20);
    line(0, 10);
    check(rb - ra === 16'h0005 && st[ST_LOADA] === 1'b1 && st[ST_LOADB] === 1'b1, "bad capture");
    check(clk_en === 1'b0, "load B did not disable clock");
    check(irq === 1'b0 && st[ST_OVRUN] === 1'b0, "early overrun");
    line(0, 10);
    check(st[ST_OVRUN] === 1'b1 && irq === 1'b1, "overrun not flagged");
    pulse(4);
    wait_cyc(1);
    check(st === ST_RESET && irq === 1'b0, "status read did not clear");
    @(posedge sys_clk);
    lda_edge <= EDGE_NONE;
    pulse(2);
    line(0, 10);
    check(st[ST_LOADB] === 1'b0, "B loaded without A");
    @(posedge sys_clk);
    ldb_dis <= 1'b0;
    ldb_stop <= 1'b1;
    lda_edge <= EDGE_RISING;
    pulse(0);
    pulse(2);
    line(0, 6);
    span(20);
    check(d === 16'h0000 && clk_en === 1'b1, "load B did not stop clock");
    @(posedge sys_clk);
    ldb_stop <= 1'b0;
    lda_edge <= EDGE_NONE;
  endtask : t_capture
  task automatic t_ext_clock;
    @(posedge sys_clk);
    src <= CLKSRC_EXT0;
    run <= 1'b1;
    pulse(0);
    pulse(2);
    wait_cyc(20);
    span(60);
    check(d === 16'h000A, "external clock rate wrong");
    @(posedge sys_clk);
    inv <= 1'b1;
    wait_cyc(12);
    span(60);
    check(d === 16'h000A, "inverted clock rate wrong");
    @(posedge sys_clk);
    inv <= 1'b0;
    chain <= {2'h0, CHAIN_SIB0, CHAIN_PIN};
    burst <= 2'h2;
    wait_cyc(12);
    span(60);
    check(d === 16'h0000, "gate low passed clock");
    @(posedge sys_clk);
    sib <= 2'b01;
    wait_cyc(12);
    span(60);
    check(d === 16'h000A, "chained gate high blocked clock");
    @(posedge sys_clk);
    run <= 1'b0;
    @(posedge sys_clk);
    wave <= 1'b1;
    wait_cyc(1);
    check(a_oe === 1'b1 && b_oe === 1'b0, "waveform line directions wrong");
    @(posedge sys_clk);
    ev_en <= 1'b1;
    etrg_edge <= EDGE_RISING;
    pulse(4);
    line(1, 6);
    check(st[ST_EXTTRG] === 1'b1, "waveform external event did not trigger");
    @(posedge sys_clk);
    ev_en <= 1'b0;
    etrg_edge <= EDGE_NONE;
    src <= 3'h0;
    cpc_dis <= 1'b1;
    pulse(2);
    wait_cyc(60);
    check(clk_en === 1'b0 && cv === 16'h0014, "compare C did not disable clock");
    @(posedge sys_clk);
    cpc_dis <= 1'b0;
    wave <= 1'b0;
    wait_cyc(1);
    check(a_oe === 1'b0 && b_oe === 1'b0, "capture lines not inputs");
  endtask : t_ext_clock
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    wait_cyc(1);
    check(cv === 16'h0000 && st === ST_RESET && clk_en === 1'b0 && irq === 1'b0, "reset state");
    t_rates;
    t_clock_ctrl;
    t_triggers;
    t_capture;
    t_ext_clock;
    stop_test;
  end
endmodule : test_tcc_channel
